// ==== design/slp_timing_top.sv ====
// panel timing generator, data serializer and palette maps with apb registers
//
// Behaviour
// - frame sync high for whole first line
// - select 0: ac bias toggles each frame
// - select 1: ac bias toggles every N line syncs
// - four lanes dual scan, eight single scan
// - pixel clock is bus clock over 2*divider
// - line and frame lengths from timing fields
// - line sync width, then delay before pixels
// - monochrome bypasses palette maps
// - gray/colour levels dithered downstream per lane
// - 4-gray maps value n to blue nibble n
// - 16-gray uses value directly
// - colour pixel splits 3/3/2 bits
// - red and green maps, eight nibbles each
// - blue map, four nibbles
// - line sync after all line data shifted
// - data changes on pixel clock rising edge
// - dual scan: upper lanes lower half
// - level F always on, 0 always off
`timescale 1ns/100ps
module slp_timing_top (
    input wire logic pclk, // bus clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [63:0] upper_q_data, // upper queue, eight 8-bit lanes
    input wire logic upper_q_valid, // upper queue has data
    output logic upper_q_ready, // upper queue beat taken
    input wire logic [31:0] lower_q_data, // lower queue, four 8-bit lanes
    input wire logic lower_q_valid, // lower queue has data
    output logic lower_q_ready, // lower queue beat taken
    output logic [31:0] lane_level, // mapped levels to dither stage
    input wire logic [7:0] dither_bits, // dither stage answer per lane
    output logic frame_sync_out, // frame sync to panel
    output logic line_sync_out, // line sync to panel
    output logic pixel_clock_out, // pixel clock to panel
    output logic ac_bias_out, // ac bias to panel
    output logic [7:0] pixel_data_out // pixel data to panel
);
    // ****************************************************************
    // registers and decode
    // ****************************************************************
    logic [31:0] ctrl_ff;
    logic [31:0] htim_ff;
    logic [31:0] ltim_ff;
    logic [31:0] red_ff;
    logic [31:0] green_ff;
    logic [15:0] blue_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_val;
    logic [31:0] stat_val;
    logic hit;
    logic wr;

    slp_pkg::slp_state_e state_ff;
    slp_pkg::slp_state_e nxt_state;
    logic [7:0] ph_cnt_ff;
    logic [10:0] pix_idx_ff;
    logic [9:0] line_cnt_ff;
    logic start_ff;
    logic frame_sync_ff;
    logic line_sync_ff;
    logic pclk_out_ff;
    logic ac_ff;
    logic [7:0] ac_cnt_ff;
    logic [1:0] phase_ff;
    logic [31:0] lvl_ff;
    logic [7:0] data_ff;
    logic under_ff;

    logic en;
    logic dual;
    logic acsel;
    logic [1:0] mode;
    logic [9:0] div_raw;
    logic [9:0] div;
    logic [10:0] len;
    logic [9:0] flc;
    logic [7:0] cur_field;
    logic done;
    logic pc_rise;
    logic pc_fall;
    logic pc_last;
    logic act_end;
    logic line_end;
    logic frame_start;
    logic load_now;
    logic [1:0] lane_phase;
    logic [1:0] step;
    logic [2:0] phase_sum;
    logic [31:0] lvl_new;
    logic [7:0] nxt_data;

    // control field views
    assign en = ctrl_ff[slp_pkg::CTRL_EN];
    assign dual = ctrl_ff[slp_pkg::CTRL_DUAL];
    assign acsel = ctrl_ff[slp_pkg::CTRL_ACSEL];
    assign mode = ctrl_ff[slp_pkg::CTRL_MODE_LO +: 2];
    assign div_raw = ctrl_ff[slp_pkg::CTRL_DIV_LO +: slp_pkg::DIV_W];
    // values below the minimum would give a half period shorter than two bus cycles
    assign div = (div_raw < slp_pkg::DIV_MIN) ? slp_pkg::DIV_MIN : div_raw;
    assign len = htim_ff[slp_pkg::HTIM_LEN_LO +: slp_pkg::LEN_W];
    assign flc = htim_ff[slp_pkg::HTIM_FLC_LO +: slp_pkg::FLC_W];

    // status word
    always_comb begin
        stat_val = 32'h0000_0000;
        stat_val[slp_pkg::STAT_LINE_LO +: slp_pkg::FLC_W] = line_cnt_ff;
        stat_val[slp_pkg::STAT_AC] = ac_ff;
        stat_val[slp_pkg::STAT_FS] = frame_sync_ff;
        stat_val[slp_pkg::STAT_UND] = under_ff;
    end

    // read mux and address hit
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            slp_pkg::ADDR_CTRL: rd_val = ctrl_ff;
            slp_pkg::ADDR_HTIM: rd_val = htim_ff;
            slp_pkg::ADDR_LTIM: rd_val = ltim_ff;
            slp_pkg::ADDR_RED: rd_val = red_ff;
            slp_pkg::ADDR_GREEN: rd_val = green_ff;
            slp_pkg::ADDR_BLUE: rd_val = {16'h0000, blue_ff};
            slp_pkg::ADDR_STAT: rd_val = stat_val;
            default: hit = 1'b0;
        endcase
    end

    // zero-wait slave: data captured in setup, answered in access
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_ff <= rd_val;
        end
    end

    // writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= slp_pkg::CTRL_RST;
            htim_ff <= slp_pkg::HTIM_RST;
            ltim_ff <= slp_pkg::LTIM_RST;
            red_ff <= slp_pkg::MAP_RST;
            green_ff <= slp_pkg::MAP_RST;
            blue_ff <= slp_pkg::MAP_RST[15:0];
        end else if (wr) begin
            if (paddr == slp_pkg::ADDR_CTRL) ctrl_ff <= pwdata;
            if (paddr == slp_pkg::ADDR_HTIM) htim_ff <= pwdata;
            if (paddr == slp_pkg::ADDR_LTIM) ltim_ff <= pwdata;
            if (paddr == slp_pkg::ADDR_RED) red_ff <= pwdata;
            if (paddr == slp_pkg::ADDR_GREEN) green_ff <= pwdata;
            if (paddr == slp_pkg::ADDR_BLUE) blue_ff <= pwdata[15:0];
        end
    end

    // ****************************************************************
    // line sequencer
    // ****************************************************************
    slp_pclk_gen u_pclk_gen (
        .pclk(pclk),
        .presetn(presetn),
        .clr(state_ff != slp_pkg::ST_ACT),
        .hold(!en),
        .div(div),
        .rise(pc_rise),
        .fall(pc_fall),
        .last(pc_last)
    );

    // field of the current non-pixel phase; 0 behaves as 1 cycle
    always_comb begin
        cur_field = 8'h00;
        unique case (state_ff)
            slp_pkg::ST_ACT: cur_field = 8'h00;
            slp_pkg::ST_SYNC: cur_field = ltim_ff[slp_pkg::LTIM_WLH_LO +: 8];
            slp_pkg::ST_DLY: cur_field = ltim_ff[slp_pkg::LTIM_DLY_LO +: 8];
            slp_pkg::ST_BLK: cur_field = ltim_ff[slp_pkg::LTIM_BLK_LO +: 8];
        endcase
    end

    assign done = (ph_cnt_ff + 8'h01) >= cur_field;
    assign act_end = en && (state_ff == slp_pkg::ST_ACT) && pc_last && (pix_idx_ff == len);
    assign line_end = en && (state_ff == slp_pkg::ST_BLK) && done;
    assign frame_start = line_end && (start_ff || (line_cnt_ff == flc));

    // next phase; everything freezes while video is off
    always_comb begin
        nxt_state = state_ff;
        if (en) begin
            unique case (state_ff)
                slp_pkg::ST_ACT: if (act_end) nxt_state = slp_pkg::ST_SYNC;
                slp_pkg::ST_SYNC: if (done) nxt_state = slp_pkg::ST_DLY;
                slp_pkg::ST_DLY: if (done) nxt_state = slp_pkg::ST_BLK;
                slp_pkg::ST_BLK: if (done) nxt_state = slp_pkg::ST_ACT;
            endcase
        end
    end

    // phase and phase-cycle counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= slp_pkg::ST_BLK;
            ph_cnt_ff <= 8'h00;
        end else if (en) begin
            state_ff <= nxt_state;
            ph_cnt_ff <= (nxt_state != state_ff) ? 8'h00 : ph_cnt_ff + 8'h01;
        end
    end

    // pixel clocks within the line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_idx_ff <= 11'h000;
        end else if (line_end) begin
            pix_idx_ff <= 11'h000;
        end else if (en && state_ff == slp_pkg::ST_ACT && pc_last) begin
            pix_idx_ff <= pix_idx_ff + 11'h001;
        end
    end

    // line counter and frame sync over the entire first line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_cnt_ff <= 10'h000;
            start_ff <= 1'b1;
            frame_sync_ff <= 1'b0;
        end else if (frame_start) begin
            line_cnt_ff <= 10'h000;
            start_ff <= 1'b0;
            frame_sync_ff <= 1'b1;
        end else if (line_end) begin
            line_cnt_ff <= line_cnt_ff + 10'h001;
            frame_sync_ff <= 1'b0;
        end
    end

    // line sync tracks the sync phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_sync_ff <= 1'b0;
        end else begin
            line_sync_ff <= (nxt_state == slp_pkg::ST_SYNC);
        end
    end

    // ac bias: per frame, or every N line syncs (N of 0 acts as 1)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ac_ff <= 1'b0;
            ac_cnt_ff <= 8'h00;
        end else if (frame_start) begin
            ac_cnt_ff <= 8'h00;
            if (!acsel) ac_ff <= !ac_ff;
        end else if (acsel && act_end) begin
            if ((ac_cnt_ff + 8'h01) >= ltim_ff[slp_pkg::LTIM_ACN_LO +: 8]) begin
                ac_ff <= !ac_ff;
                ac_cnt_ff <= 8'h00;
            end else begin
                ac_cnt_ff <= ac_cnt_ff + 8'h01;
            end
        end
    end

    // ****************************************************************
    // data path
    // ****************************************************************
    // next pixel is fetched half a period ahead, the first one in blank
    assign load_now = line_end ||
        (en && state_ff == slp_pkg::ST_ACT && pc_fall && pix_idx_ff != len);
    assign upper_q_ready = load_now;
    assign lower_q_ready = load_now && dual;

    // colour subpixel phase of lane 0, restarting every line
    assign lane_phase = line_end ? 2'h0 : phase_ff;
    assign step = dual ? 2'h1 : 2'h2;
    assign phase_sum = {1'b0, lane_phase} + {1'b0, step};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 2'h0;
        end else if (load_now) begin
            phase_ff <= (phase_sum >= 3'h3) ? 2'(phase_sum - 3'h3) : phase_sum[1:0];
        end
    end

    // one palette per lane
    genvar gi;
    generate
        for (gi = 0; gi < slp_pkg::LANES; gi = gi + 1) begin : g_lane
            logic [7:0] val;
            logic [3:0] ksum;
            logic [1:0] kind;
            logic [3:0] lvl;
            if (gi >= 4) begin : g_hi
                // dual scan puts the lower half on the upper lanes
                assign val = dual ? lower_q_data[(gi - 4) * 8 +: 8] :
                    upper_q_data[gi * 8 +: 8];
            end else begin : g_lo
                assign val = upper_q_data[gi * 8 +: 8];
            end
            assign ksum = {2'b00, lane_phase} + (dual ? 4'(gi % 4) : 4'(gi));
            assign kind = 2'(ksum % 4'h3);
            slp_palette u_palette (
                .mode(mode),
                .kind(kind),
                .val(val),
                .red_map(red_ff),
                .green_map(green_ff),
                .blue_map(blue_ff),
                .lvl(lvl)
            );
            assign lvl_new[gi * 4 +: 4] = lvl;
            // extreme levels fixed, others take the dither answer
            assign nxt_data[gi] = (lvl_ff[gi * 4 +: 4] == slp_pkg::LVL_ON) ? 1'b1 :
                (lvl_ff[gi * 4 +: 4] == slp_pkg::LVL_OFF) ? 1'b0 :
                dither_bits[gi];
        end
    endgenerate

    // levels held for the dither stage until the next fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_ff <= 32'h0000_0000;
        end else if (load_now) begin
            lvl_ff <= lvl_new;
        end
    end

    // panel data and pixel clock move together on the rising point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= 8'h00;
            pclk_out_ff <= 1'b0;
        end else if (pc_rise) begin
            data_ff <= nxt_data;
            pclk_out_ff <= 1'b1;
        end else if (pc_fall) begin
            pclk_out_ff <= 1'b0;
        end
    end

    // underrun is sticky; a new one wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            under_ff <= 1'b0;
        end else if (load_now && (!upper_q_valid || (dual && !lower_q_valid))) begin
            under_ff <= 1'b1;
        end else if (wr && paddr == slp_pkg::ADDR_STAT && pwdata[slp_pkg::STAT_UND]) begin
            under_ff <= 1'b0;
        end
    end

    // outputs
    assign lane_level = lvl_ff;
    assign frame_sync_out = frame_sync_ff;
    assign line_sync_out = line_sync_ff;
    assign pixel_clock_out = pclk_out_ff;
    assign ac_bias_out = ac_ff;
    assign pixel_data_out = data_ff;
endmodule

// ==== design/slp_pkg.sv ====
// shared constants for the passive-matrix panel timing and palette block
package slp_pkg;
    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HTIM = 8'h04;
    localparam logic [7:0] ADDR_LTIM = 8'h08;
    localparam logic [7:0] ADDR_RED = 8'h0C;
    localparam logic [7:0] ADDR_GREEN = 8'h10;
    localparam logic [7:0] ADDR_BLUE = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;

    // ****************************************************************
    // field positions and widths
    // ****************************************************************
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_DUAL = 3;
    localparam int CTRL_ACSEL = 4;
    localparam int CTRL_DIV_LO = 16;
    localparam int HTIM_LEN_LO = 0;
    localparam int HTIM_FLC_LO = 16;
    localparam int LTIM_WLH_LO = 0;
    localparam int LTIM_DLY_LO = 8;
    localparam int LTIM_BLK_LO = 16;
    localparam int LTIM_ACN_LO = 24;
    localparam int STAT_LINE_LO = 0;
    localparam int STAT_AC = 16;
    localparam int STAT_FS = 17;
    localparam int STAT_UND = 18;
    localparam int DIV_W = 10;
    localparam int LEN_W = 11;
    localparam int FLC_W = 10;
    localparam int LANES = 8;

    // ****************************************************************
    // reset values and limits
    // ****************************************************************
    localparam logic [31:0] CTRL_RST = 32'h0002_0000;
    localparam logic [31:0] HTIM_RST = 32'h0000_0000;
    localparam logic [31:0] LTIM_RST = 32'h0000_0000;
    localparam logic [31:0] MAP_RST = 32'h0000_0000;
    localparam logic [9:0] DIV_MIN = 10'h002;
    localparam logic [3:0] LVL_ON = 4'hF;
    localparam logic [3:0] LVL_OFF = 4'h0;

    // display data modes
    typedef enum logic [1:0] {
        SLP_MONO,
        SLP_GRAY4,
        SLP_GRAY16,
        SLP_COLOR
    } slp_mode_e;

    // line phases
    typedef enum logic [1:0] {
        ST_ACT,
        ST_SYNC,
        ST_DLY,
        ST_BLK
    } slp_state_e;
endpackage

// ==== design/slp_pclk_gen.sv ====
// pixel clock divider: one period is twice the divider in bus clocks
`timescale 1ns/100ps
module slp_pclk_gen (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic clr, // restart the period at zero
    input wire logic hold, // freeze the count
    input wire logic [9:0] div, // divider, already clamped
    output logic rise, // pixel clock rising point
    output logic fall, // pixel clock falling point
    output logic last // final bus cycle of the period
);
    logic [10:0] cnt_ff;
    logic [10:0] per;
    logic run;

    // period bounds
    assign per = {div, 1'b0};
    assign run = !clr && !hold;
    assign rise = run && (cnt_ff == 11'h000);
    assign fall = run && (cnt_ff == {1'b0, div});
    assign last = run && (cnt_ff == per - 11'h001);

    // free count while running, held while frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 11'h000;
        end else if (clr) begin
            cnt_ff <= 11'h000;
        end else if (!hold) begin
            cnt_ff <= last ? 11'h000 : cnt_ff + 11'h001;
        end
    end
endmodule

// ==== design/slp_palette.sv ====
// one data lane: maps a pixel value to a 4-bit level
`timescale 1ns/100ps
module slp_palette (
    input wire logic [1:0] mode, // display data mode
    input wire logic [1:0] kind, // subpixel: 0 red, 1 green, 2 blue
    input wire logic [7:0] val, // raw lane value
    input wire logic [31:0] red_map, // red level map
    input wire logic [31:0] green_map, // green level map
    input wire logic [15:0] blue_map, // blue and 4-gray level map
    output logic [3:0] lvl // mapped level
);
    // mode dependent selection
    always_comb begin
        lvl = slp_pkg::LVL_OFF;
        unique case (slp_pkg::slp_mode_e'(mode))
            slp_pkg::SLP_MONO: lvl = {4{val[0]}};
            slp_pkg::SLP_GRAY4: lvl = blue_map[{val[1:0], 2'b00} +: 4];
            slp_pkg::SLP_GRAY16: lvl = val[3:0];
            slp_pkg::SLP_COLOR: begin
                // red 7:5, green 4:2, blue 1:0
                if (kind == 2'h0) begin
                    lvl = red_map[{val[7:5], 2'b00} +: 4];
                end else if (kind == 2'h1) begin
                    lvl = green_map[{val[4:2], 2'b00} +: 4];
                end else begin
                    lvl = blue_map[{val[1:0], 2'b00} +: 4];
                end
            end
        endcase
    end
endmodule

// ==== verif/slp_asserts.sv ====
// checker of panel link timing and bus answers, bound to the top module
`timescale 1ns/100ps
module slp_asserts (
    input wire logic pclk, // bus clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic [7:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic frame_sync_out, // frame sync
    input wire logic line_sync_out, // line sync
    input wire logic pixel_clock_out, // pixel clock
    input wire logic ac_bias_out, // ac bias
    input wire logic [7:0] pixel_data_out // pixel data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // zero wait states, unmapped or unaligned places refused
    property p_rdy; psel && penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("access without ready");
    property p_err; psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    // sync only after the last pixel period, with a quiet delay behind it
    property p_lsync_gap; $rose(line_sync_out) |-> !pixel_clock_out && !$past(pixel_clock_out);
    endproperty
    a_lsync_gap: assert property (p_lsync_gap) else $error("line sync over pixels");
    property p_sync_quiet; line_sync_out |=> !pixel_clock_out; endproperty
    a_sync_quiet: assert property (p_sync_quiet) else $error("pixel clock too soon");
    // data may only move with a rising pixel clock, which lasts two cycles at least
    property p_data_edge; $changed(pixel_data_out) |-> $rose(pixel_clock_out); endproperty
    a_data_edge: assert property (p_data_edge) else $error("data off the rising edge");
    property p_clk_high; $rose(pixel_clock_out) |-> pixel_clock_out [*2]; endproperty
    a_clk_high: assert property (p_clk_high) else $error("pixel clock high too short");
    // frame sync and ac bias switch only between pixel periods
    property p_frame_line; $changed(frame_sync_out) |-> !line_sync_out && !pixel_clock_out;
    endproperty
    a_frame_line: assert property (p_frame_line) else $error("frame sync mid line");
    property p_ac_quiet; $changed(ac_bias_out) |-> !pixel_clock_out; endproperty
    a_ac_quiet: assert property (p_ac_quiet) else $error("ac bias mid pixel");
endmodule
bind slp_timing_top slp_asserts slp_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out),
    .pixel_clock_out(pixel_clock_out), .ac_bias_out(ac_bias_out),
    .pixel_data_out(pixel_data_out));

// ==== verif/slp_panel_model.sv ====
// panel driver model: takes one data byte per falling pixel clock
`timescale 1ns/100ps
module slp_panel_model (
    input wire logic pixel_clock_out, // pixel clock from block
    input wire logic [7:0] pixel_data_out, // pixel data from block
    output logic [7:0] px, // last byte shifted in
    output logic [31:0] px_cnt // bytes shifted in so far
);
    logic hi;
    initial px_cnt = 32'h0;
    initial hi = 1'b0;
    // arm on a real high so the power-up settle is not taken as a sample
    always @(posedge pixel_clock_out) hi = 1'b1;
    always @(negedge pixel_clock_out) begin
        if (hi) begin
            px <= pixel_data_out;
            px_cnt <= px_cnt + 32'h1;
        end
    end
endmodule

// ==== verif/tb.sv ====
// self-checking bench: registers, per-mode pixel mapping, line and frame timing
`timescale 1ns/100ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ls_d, sel_s;
    logic upper_q_ready, lower_q_ready, frame_sync_out, line_sync_out;
    logic pixel_clock_out, ac_bias_out;
    logic [7:0] paddr, dither_bits, pixel_data_out, px;
    logic [31:0] pwdata, prdata, lower_q_data, lane_level, rd, px_cnt, red_s, green_s;
    logic [15:0] blue_s;
    logic [63:0] upper_q_data;
    logic [1:0] mode_s;
    logic [7:0] exp_q[$];
    int err_total, checks, beat;
    slp_timing_top slp_timing_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .upper_q_data(upper_q_data),
        .upper_q_valid(1'b1), .upper_q_ready(upper_q_ready), .lower_q_data(lower_q_data),
        .lower_q_valid(1'b1), .lower_q_ready(lower_q_ready), .lane_level(lane_level),
        .dither_bits(dither_bits), .frame_sync_out(frame_sync_out),
        .line_sync_out(line_sync_out), .pixel_clock_out(pixel_clock_out),
        .ac_bias_out(ac_bias_out), .pixel_data_out(pixel_data_out));
    slp_panel_model slp_panel_model_i (.pixel_clock_out(pixel_clock_out),
        .pixel_data_out(pixel_data_out), .px(px), .px_cnt(px_cnt));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ****************************************************************
    // report and compare
    // ****************************************************************
    task end_of_test;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task cmp32(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task cmp_px(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t pixel got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer, request held until ready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
        if (n == 50) begin
            err_total++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // expected panel byte for one beat; mapping fixed at fetch time
    function automatic logic [7:0] px_exp(input logic [63:0] d, input int ph);
        logic [7:0] v, r;
        logic [3:0] l;
        int p;
        for (int i = 0; i < 8; i++) begin
            v = d[8*i+:8];
            p = ph + (mode_s[1] ? i % 4 : i);
            case (mode_s)
                2'h1: l = blue_s[4*v[1:0]+:4];
                2'h2: l = v[3:0];
                2'h3: l = (p % 3 == 0) ? red_s[4*v[7:5]+:4] :
                    (p % 3 == 1) ? green_s[4*v[4:2]+:4] : blue_s[4*v[1:0]+:4];
                default: l = {3'h0, v[0]};
            endcase
            r[i] = (mode_s == 2'h0) ? v[0] : (l == 4'hF) ? 1'b1 : (l == 4'h0) ? 1'b0 :
                dither_bits[i];
        end
        return r;
    endfunction
    // queue source: new random beat after each take, expectation noted
    always @(posedge pclk) begin
        ls_d <= line_sync_out;
        if (line_sync_out && !ls_d) beat = 0;
        if (upper_q_ready === 1'b1) begin
            exp_q.push_back(px_exp(mode_s[1] ? {lower_q_data, upper_q_data[31:0]} : upper_q_data,
                (mode_s[1] ? beat : 2 * beat) % 3));
            beat = beat + 1;
            upper_q_data <= {$urandom, $urandom};
            lower_q_data <= $urandom;
        end
    end
    always @(px_cnt) begin
        if (px_cnt > 0) begin
            if (exp_q.size() > 0) cmp_px(px, exp_q.pop_front());
            else cmp_px(px, ~px);
        end
    end
    // period between sync rises and ac bias flip across it
    task meas(input logic fr);
        int n, t, n0;
        logic a0, prev;
        t = 0;
        n0 = 0;
        prev = fr ? frame_sync_out : line_sync_out;
        for (n = 0; n < 400 && t < 3; n++) begin
            @(posedge pclk);
            if ((fr ? frame_sync_out : line_sync_out) && !prev) begin
                if (t > 0) cmp32(n - n0, fr ? 32'd50 : 32'd25);
                if (t > 0) cmp32({31'h0, ac_bias_out},
                    {31'h0, a0 ^ (sel_s | frame_sync_out)});
                t++;
                n0 = n;
                a0 = ac_bias_out;
            end
            prev = fr ? frame_sync_out : line_sync_out;
        end
        if (t < 3) begin
            err_total++;
            end_of_test();
        end
    endtask
    // freeze, load fresh maps, restart in a mode; sel picks the ac bias rule
    task run(input logic [1:0] m, input logic sel);
        apb(1'b1, slp_pkg::ADDR_CTRL, 32'h0002_0000);
        red_s = $urandom;
        green_s = $urandom;
        blue_s = $urandom;
        mode_s = m;
        sel_s = sel;
        apb(1'b1, slp_pkg::ADDR_RED, red_s);
        apb(1'b1, slp_pkg::ADDR_GREEN, green_s);
        apb(1'b1, slp_pkg::ADDR_BLUE, {16'h0, blue_s});
        apb(1'b1, slp_pkg::ADDR_CTRL, {6'h0, 10'h002, 11'h0, sel, m[1], m, 1'b1});
        meas(!sel);
        meas(1'b0);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        err_total = 0;
        checks = 0;
        beat = 0;
        mode_s = 2'h0;
        rd = $urandom(32'hC317);
        upper_q_data = {$urandom, $urandom};
        lower_q_data = $urandom;
        dither_bits = $urandom;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, slp_pkg::ADDR_CTRL, 32'h0);
        cmp32(rd, slp_pkg::CTRL_RST);
        apb(1'b0, slp_pkg::ADDR_RED, 32'h0);
        cmp32(rd, slp_pkg::MAP_RST);
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        cmp32({31'h0, er}, 32'h1);
        apb(1'b0, 8'h1D, 32'h0);
        cmp32({rd[31:1], er}, 32'h1);
        apb(1'b1, slp_pkg::ADDR_HTIM, 32'h0001_0003);
        apb(1'b1, slp_pkg::ADDR_LTIM, 32'h0104_0203);
        apb(1'b0, slp_pkg::ADDR_LTIM, 32'h0);
        cmp32(rd, 32'h0104_0203);
        for (int m = 0; m < 4; m++) run(m[1:0], m[0]);
        end_of_test();
    end
endmodule
